// *** ib_defs.svh ***
// timing counts, command codes and fifo sizes for the instrument bus ends
// assumes a 250 MHz system clock on both ends
`ifndef IB_DEFS_SVH
`define IB_DEFS_SVH
`define CLK_MHZ 250
// data settling time before a byte is flagged valid
`define SETTLE_NS 500
`define SETTLE_CYC ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define ADDR_MAX 5'h1E
`define GRP_LISTEN 2'h1
`define GRP_TALK 2'h2
`define CMD_UNLISTEN 8'h3F
`define CMD_UNTALK 8'h5F
`define CHAR_CR 8'h0D
`define CHAR_LF 8'h0A
`define TERM_EOI 1'b0
`define TERM_CRLF 1'b1
`define FIFO_DEPTH 4
`define RX_WIDTH 9
`endif

// *** ib_pkg.sv ***
// types and shared decoding for both instrument bus ends
// assumes ib_defs.svh is on the include path
`include "ib_defs.svh"
package ib_pkg;
	typedef enum logic [2:0] {OP_LISTEN, OP_TALK, OP_UNLISTEN, OP_UNTALK, OP_DATA, OP_READ} host_op_t;
	typedef enum logic [1:0] {A_IDLE, A_RDY, A_ACC} acc_state_t;
	typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_DAV} src_state_t;
	typedef enum logic [2:0] {H_IDLE, H_SETTLE, H_DAV, H_RDY, H_ACC} host_state_t;

	// addressing byte sent under attention
	function automatic logic [7:0] cmd_byte(input host_op_t op, input logic [4:0] addr);
		unique case (op)
			OP_LISTEN: cmd_byte = {1'b0, `GRP_LISTEN, addr};
			OP_TALK: cmd_byte = {1'b0, `GRP_TALK, addr};
			OP_UNLISTEN: cmd_byte = `CMD_UNLISTEN;
			OP_UNTALK: cmd_byte = `CMD_UNTALK;
			default: cmd_byte = 8'h00;
		endcase
	endfunction : cmd_byte

	// message end test for the selected terminator convention
	function automatic logic msg_end(input logic eoi, input logic [7:0] b, input logic mode);
		msg_end = eoi && (mode == `TERM_EOI || b == `CHAR_LF);
	endfunction : msg_end
endpackage : ib_pkg

// *** ib_bus_if.sv ***
// instrument bus wires: eight data, three handshake, five management lines
// every line is modelled asserted-high; drivers are wired-or per line
interface ib_bus_if;
	logic [7:0] c_dio;
	logic c_dio_oe;
	logic c_dav, c_nrfd, c_ndac, c_atn, c_eoi, c_ifc, c_ren;
	logic [7:0] d_dio;
	logic d_dio_oe;
	logic d_dav, d_nrfd, d_ndac, d_eoi, d_srq;
	logic [7:0] dio;
	logic dav, nrfd, ndac, atn, eoi, ifc, ren, srq;

	// resolve the shared wires from both ends' drives
	assign dio = (c_dio_oe ? c_dio : 8'h00) | (d_dio_oe ? d_dio : 8'h00);
	assign dav = c_dav | d_dav;
	assign nrfd = c_nrfd | d_nrfd;
	assign ndac = c_ndac | d_ndac;
	assign eoi = c_eoi | d_eoi;
	assign atn = c_atn;
	assign ifc = c_ifc;
	assign ren = c_ren;
	assign srq = d_srq;

	modport ctl (output c_dio, c_dio_oe, c_dav, c_nrfd, c_ndac, c_atn, c_eoi, c_ifc, c_ren,
		input dio, dav, nrfd, ndac, atn, eoi, ifc, ren, srq);
	modport dev (output d_dio, d_dio_oe, d_dav, d_nrfd, d_ndac, d_eoi, d_srq,
		input dio, dav, nrfd, ndac, atn, eoi, ifc, ren, srq);
endinterface : ib_bus_if

// *** ib_device.sv ***
// instrument end of the bus: addressing, acceptor, source and receive fifo
// assumes a controller on ib_bus_if.ctl and one clock for all logic
// Behaviour
// - bytes move eight bits parallel, one after another
// - three handshake lines, five management lines
// - answer one configured address, zero to thirty
// - never listener and talker at once
// - controller addresses listener before sending bytes
// - listener signals readiness on handshake lines
// - sender flags byte valid after placing it
// - listener accepts, then sender removes byte
// - end by eoi, or cr lf with eoi
// - controller unlistens, then talks device for reply
// - talker drives reply byte and flags it
// - controller acknowledges reply bytes until eoi
// - terminator convention selected by setting
// - primary address only, secondaries ignored
`include "ib_defs.svh"

// ----------------------------------------
// receive fifo
// ----------------------------------------
module ib_fifo #(
	parameter int WIDTH = `RX_WIDTH,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [AW:0] count_reg, count_next;
	logic push, pop;

	// pointers wrap naturally, so depth is a power of two
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_data_o = mem_reg[rd_ptr_reg];

	// storage write
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	// pointers, fill count and registered flags
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			in_ready_o <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_next;
			in_ready_o <= count_next != (AW+1)'(DEPTH);
			out_valid_o <= count_next != '0;
		end
	end
endmodule : ib_fifo

// ----------------------------------------
// device end
// ----------------------------------------
module ib_device
	import ib_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	ib_bus_if.dev bus,
	input wire logic [4:0] my_addr_i,
	input wire logic term_mode_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_end_o,
	input wire logic rx_ready_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_last_i,
	output logic tx_ready_o,
	output logic listening_o,
	output logic talking_o
);
	logic [13:0] raw, s1_reg, s2_reg, s3_reg, in_reg;
	logic atn_s, ifc_s, eoi_s, dav_s, nrfd_s, ndac_s;
	logic [7:0] dio_s;
	acc_state_t acc_state;
	src_state_t src_state;
	logic nrfd_reg, ndac_reg, cmd_take_reg, push_reg, end_reg;
	logic [7:0] byte_reg;
	logic listen_reg, talk_reg;
	logic acc_active, acc_ready, fifo_in_ready, can_send, take;
	logic [7:0] dio_reg, out_byte_reg;
	logic dio_oe_reg, dav_reg, eoi_reg, out_eoi_reg, pending_reg;
	logic [1:0] tail_reg;
	logic [7:0] cnt_reg;

	// bus inputs, one line per bit, handshake and management lines apart
	assign raw = {bus.atn, bus.ifc, bus.eoi, bus.dav, bus.nrfd, bus.ndac, bus.dio};
	assign {atn_s, ifc_s, eoi_s, dav_s, nrfd_s, ndac_s, dio_s} = in_reg;

	// three-stage synchroniser, a change counts when stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			in_reg <= '0;
		end else begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			in_reg <= (s2_reg & s3_reg) | (in_reg & (s2_reg | s3_reg));
		end
	end

	// ----------------------------------------
	// acceptor handshake
	// ----------------------------------------
	assign acc_active = atn_s || listen_reg;
	assign acc_ready = atn_s || fifo_in_ready;

	// ready, take byte, accept, wait for valid to drop
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			acc_state <= A_IDLE;
			nrfd_reg <= 1'b0;
			ndac_reg <= 1'b0;
			cmd_take_reg <= 1'b0;
			push_reg <= 1'b0;
			byte_reg <= 8'h00;
			end_reg <= 1'b0;
		end else begin
			cmd_take_reg <= 1'b0;
			push_reg <= 1'b0;
			unique case (acc_state)
				A_IDLE: begin
					nrfd_reg <= acc_active;
					ndac_reg <= acc_active;
					if (acc_active && acc_ready && !dav_s) begin
						nrfd_reg <= 1'b0;
						acc_state <= A_RDY;
					end
				end
				A_RDY: begin
					if (!acc_active) begin
						nrfd_reg <= 1'b0;
						ndac_reg <= 1'b0;
						acc_state <= A_IDLE;
					end else if (dav_s) begin
						byte_reg <= dio_s;
						end_reg <= msg_end(eoi_s, dio_s, term_mode_i);
						cmd_take_reg <= atn_s;
						push_reg <= !atn_s;
						nrfd_reg <= 1'b1;
						ndac_reg <= 1'b0;
						acc_state <= A_ACC;
					end
				end
				A_ACC: begin
					if (!dav_s) begin
						nrfd_reg <= acc_active;
						ndac_reg <= acc_active;
						acc_state <= A_IDLE;
					end
				end
				default: acc_state <= A_IDLE;
			endcase
		end
	end

	ib_fifo #(.WIDTH(`RX_WIDTH), .DEPTH(`FIFO_DEPTH)) u_rx_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push_reg),
		.in_data_i({end_reg, byte_reg}),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(rx_valid_o),
		.out_data_o({rx_end_o, rx_data_o}),
		.out_ready_i(rx_ready_i)
	);

	// ----------------------------------------
	// addressing
	// ----------------------------------------
	// secondary group bytes match no branch and are dropped
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			listen_reg <= 1'b0;
			talk_reg <= 1'b0;
		end else if (ifc_s) begin
			listen_reg <= 1'b0;
			talk_reg <= 1'b0;
		end else if (cmd_take_reg) begin
			if ({1'b0, byte_reg[6:0]} == `CMD_UNLISTEN) begin
				listen_reg <= 1'b0;
			end else if ({1'b0, byte_reg[6:0]} == `CMD_UNTALK) begin
				talk_reg <= 1'b0;
			end else if (byte_reg[6:5] == `GRP_LISTEN && my_addr_i <= `ADDR_MAX
				&& byte_reg[4:0] == my_addr_i) begin
				listen_reg <= 1'b1;
				talk_reg <= 1'b0;
			end else if (byte_reg[6:5] == `GRP_TALK) begin
				talk_reg <= my_addr_i <= `ADDR_MAX && byte_reg[4:0] == my_addr_i;
				if (my_addr_i <= `ADDR_MAX && byte_reg[4:0] == my_addr_i) begin
					listen_reg <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// source handshake
	// ----------------------------------------
	assign can_send = talk_reg && !atn_s;
	assign take = tx_valid_i && tx_ready_o;

	// load byte, drive and settle, flag valid, release on acceptance
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			src_state <= S_IDLE;
			dio_reg <= 8'h00;
			dio_oe_reg <= 1'b0;
			dav_reg <= 1'b0;
			eoi_reg <= 1'b0;
			out_byte_reg <= 8'h00;
			out_eoi_reg <= 1'b0;
			pending_reg <= 1'b0;
			tail_reg <= 2'h0;
			cnt_reg <= 8'h00;
		end else begin
			unique case (src_state)
				S_IDLE: begin
					if (take) begin
						out_byte_reg <= tx_data_i;
						out_eoi_reg <= tx_last_i && term_mode_i == `TERM_EOI;
						tail_reg <= (tx_last_i && term_mode_i == `TERM_CRLF) ? 2'h2 : 2'h0;
						pending_reg <= 1'b1;
					end else if (pending_reg && can_send) begin
						dio_reg <= out_byte_reg;
						dio_oe_reg <= 1'b1;
						eoi_reg <= out_eoi_reg;
						cnt_reg <= 8'(`SETTLE_CYC - 1);
						src_state <= S_SETTLE;
					end else if (tail_reg != 2'h0 && can_send) begin
						out_byte_reg <= (tail_reg == 2'h2) ? `CHAR_CR : `CHAR_LF;
						out_eoi_reg <= tail_reg == 2'h1;
						tail_reg <= tail_reg - 2'h1;
						pending_reg <= 1'b1;
					end
				end
				S_SETTLE: begin
					if (!can_send) begin
						dio_oe_reg <= 1'b0;
						eoi_reg <= 1'b0;
						src_state <= S_IDLE;
					end else if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else if (!nrfd_s && ndac_s) begin
						dav_reg <= 1'b1;
						src_state <= S_DAV;
					end
				end
				S_DAV: begin
					if (!can_send || !ndac_s) begin
						dav_reg <= 1'b0;
						dio_oe_reg <= 1'b0;
						eoi_reg <= 1'b0;
						pending_reg <= !can_send;
						src_state <= S_IDLE;
					end
				end
				default: src_state <= S_IDLE;
			endcase
		end
	end

	// user ready, held low while a byte or terminator waits
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tx_ready_o <= 1'b0;
		end else begin
			tx_ready_o <= src_state == S_IDLE && !take && !pending_reg && tail_reg == 2'h0;
		end
	end

	// role status
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			listening_o <= 1'b0;
			talking_o <= 1'b0;
		end else begin
			listening_o <= listen_reg;
			talking_o <= talk_reg;
		end
	end

	// bus drives
	assign bus.d_dio = dio_reg;
	assign bus.d_dio_oe = dio_oe_reg;
	assign bus.d_dav = dav_reg;
	assign bus.d_eoi = eoi_reg;
	assign bus.d_nrfd = nrfd_reg;
	assign bus.d_ndac = ndac_reg;
	assign bus.d_srq = 1'b0;
endmodule : ib_device

// *** ib_host.sv ***
// controller end of the bus: addressing, message send and reply read
// assumes one device on ib_bus_if.dev and one clock for all logic
`include "ib_defs.svh"

module ib_host
	import ib_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	ib_bus_if.ctl bus,
	input wire logic clear_i,
	input wire logic op_valid_i,
	input wire host_op_t op_i,
	input wire logic [4:0] op_addr_i,
	input wire logic [7:0] op_data_i,
	input wire logic op_eoi_i,
	output logic op_ready_o,
	output logic op_refused_o,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o,
	output logic rd_eoi_o
);
	logic [11:0] raw, s1_reg, s2_reg, s3_reg, in_reg;
	logic eoi_s, dav_s, nrfd_s, ndac_s;
	logic [7:0] dio_s;
	host_state_t state;
	logic atn_reg, ifc_reg, ren_reg, dio_oe_reg, dav_reg, eoi_reg, nrfd_reg, ndac_reg;
	logic [7:0] dio_reg, cnt_reg;
	logic listened_reg, talked_reg, take;

	assign raw = {bus.eoi, bus.dav, bus.nrfd, bus.ndac, bus.dio};
	assign {eoi_s, dav_s, nrfd_s, ndac_s, dio_s} = in_reg;
	assign take = op_valid_i && op_ready_o;

	// three-stage synchroniser, a change counts when stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			in_reg <= '0;
		end else begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			in_reg <= (s2_reg & s3_reg) | (in_reg & (s2_reg | s3_reg));
		end
	end

	// ----------------------------------------
	// transfer engine
	// ----------------------------------------
	// idle holds both acceptor lines so a talker never sees a false accept
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= H_IDLE;
			atn_reg <= 1'b0;
			dio_reg <= 8'h00;
			dio_oe_reg <= 1'b0;
			dav_reg <= 1'b0;
			eoi_reg <= 1'b0;
			nrfd_reg <= 1'b0;
			ndac_reg <= 1'b0;
			cnt_reg <= 8'h00;
			op_refused_o <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_data_o <= 8'h00;
			rd_eoi_o <= 1'b0;
		end else begin
			op_refused_o <= 1'b0;
			rd_valid_o <= 1'b0;
			unique case (state)
				H_IDLE: begin
					nrfd_reg <= 1'b1;
					ndac_reg <= 1'b1;
					if (take && op_i != OP_DATA && op_i != OP_READ) begin
						atn_reg <= 1'b1;
						dio_reg <= cmd_byte(op_i, op_addr_i);
						dio_oe_reg <= 1'b1;
						eoi_reg <= 1'b0;
						nrfd_reg <= 1'b0;
						ndac_reg <= 1'b0;
						cnt_reg <= 8'(`SETTLE_CYC - 1);
						state <= H_SETTLE;
					end else if (take && op_i == OP_DATA && listened_reg) begin
						atn_reg <= 1'b0;
						dio_reg <= op_data_i;
						dio_oe_reg <= 1'b1;
						eoi_reg <= op_eoi_i;
						nrfd_reg <= 1'b0;
						ndac_reg <= 1'b0;
						cnt_reg <= 8'(`SETTLE_CYC - 1);
						state <= H_SETTLE;
					end else if (take && op_i == OP_READ && talked_reg) begin
						atn_reg <= 1'b0;
						nrfd_reg <= 1'b0;
						state <= H_RDY;
					end else if (take) begin
						op_refused_o <= 1'b1;
					end
				end
				H_SETTLE: begin
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else if (!nrfd_s && ndac_s) begin
						dav_reg <= 1'b1;
						state <= H_DAV;
					end
				end
				H_DAV: begin
					if (!ndac_s) begin
						dav_reg <= 1'b0;
						dio_oe_reg <= 1'b0;
						eoi_reg <= 1'b0;
						nrfd_reg <= 1'b1;
						ndac_reg <= 1'b1;
						state <= H_IDLE;
					end
				end
				H_RDY: begin
					if (dav_s) begin
						rd_data_o <= dio_s;
						rd_eoi_o <= eoi_s;
						rd_valid_o <= 1'b1;
						nrfd_reg <= 1'b1;
						ndac_reg <= 1'b0;
						state <= H_ACC;
					end
				end
				H_ACC: begin
					if (!dav_s) begin
						ndac_reg <= 1'b1;
						state <= H_IDLE;
					end
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	// addressing bookkeeping, one device assumed
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || clear_i) begin
			listened_reg <= 1'b0;
			talked_reg <= 1'b0;
		end else if (take && state == H_IDLE) begin
			unique case (op_i)
				OP_LISTEN: begin
					listened_reg <= 1'b1;
					talked_reg <= 1'b0;
				end
				OP_TALK: begin
					talked_reg <= 1'b1;
					listened_reg <= 1'b0;
				end
				OP_UNLISTEN: listened_reg <= 1'b0;
				OP_UNTALK: talked_reg <= 1'b0;
				default: listened_reg <= listened_reg;
			endcase
		end
	end

	// management lines and user ready
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ifc_reg <= 1'b0;
			ren_reg <= 1'b0;
			op_ready_o <= 1'b0;
		end else begin
			ifc_reg <= clear_i;
			ren_reg <= 1'b1;
			op_ready_o <= state == H_IDLE && !take && !clear_i;
		end
	end

	assign bus.c_dio = dio_reg;
	assign bus.c_dio_oe = dio_oe_reg;
	assign bus.c_dav = dav_reg;
	assign bus.c_nrfd = nrfd_reg;
	assign bus.c_ndac = ndac_reg;
	assign bus.c_atn = atn_reg;
	assign bus.c_eoi = eoi_reg;
	assign bus.c_ifc = ifc_reg;
	assign bus.c_ren = ren_reg;
endmodule : ib_host

// *** ib_bus_monitor.sv ***
// checker for the bus joining the host and device ends
// assumes the resolved wires and per-end drives of ib_bus_if
`include "ib_defs.svh"

module ib_bus_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] dio,
	input wire logic c_dio_oe,
	input wire logic d_dio_oe,
	input wire logic d_dav,
	input wire logic dav,
	input wire logic nrfd,
	input wire logic ndac,
	input wire logic atn,
	input wire logic eoi
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] hold_cnt_reg;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// cycles the data lines have stood driven and unchanged
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !(c_dio_oe || d_dio_oe) || dio != $past(dio)) begin
			hold_cnt_reg <= 8'h00;
		end else if (hold_cnt_reg != 8'hFF) begin
			hold_cnt_reg <= hold_cnt_reg + 8'h01;
		end
	end

	// ----
	// handshake rules
	// ----
	one_driver_a: assert property (!atn |-> !(c_dio_oe && d_dio_oe))
		else $error("both ends drive the data lines");
	data_hold_a: assert property (dav && $past(dav) |-> $stable(dio) && $stable(eoi))
		else $error("data changed while flagged valid");
	dav_ready_a: assert property ($rose(dav) |-> !nrfd && ndac)
		else $error("valid raised without ready acceptor");
	settle_time_a: assert property ($rose(dav) |-> hold_cnt_reg >= `SETTLE_CYC - 8)
		else $error("valid raised before data settled");
	dav_release_a: assert property ($fell(dav) && !atn |-> !$past(ndac))
		else $error("byte removed before acceptance");
	ndac_rearm_a: assert property ($fell(dav) |-> ##[1:16] ndac)
		else $error("acceptor did not rearm");
	eoi_data_a: assert property (eoi |-> c_dio_oe || d_dio_oe)
		else $error("end flag without a byte");
	atn_abort_a: assert property ($rose(atn) |-> ##8 (!d_dav || !atn))
		else $error("device still sourcing under attention");
	talk_no_atn_a: assert property ($rose(d_dav) |-> !atn)
		else $error("device sourced under attention");

	// main scenarios reached
	cover property ($rose(d_dav));
	cover property (dav && eoi && dio == `CHAR_LF);
	cover property ((nrfd && c_dio_oe && !atn) [*8]);
endmodule : ib_bus_monitor

// *** tb_top.sv ***
// testbench: host and device joined on one bus, a fault driver on a second
// assumes ib_pkg, ib_bus_if, ib_host, ib_device and ib_bus_monitor compiled
`include "ib_defs.svh"

module tb_top
	import ib_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic clear_i = 1'b0;
	logic op_valid_i = 1'b0;
	logic op_eoi_i = 1'b0;
	host_op_t op_i = OP_LISTEN;
	logic [4:0] op_addr_i = 5'h00;
	logic [4:0] my_addr_i = `ADDR_MAX;
	logic [7:0] op_data_i = 8'h00;
	logic [7:0] tx_data_i = 8'h00;
	logic term_mode_i = `TERM_EOI;
	logic rx_ready_i = 1'b0;
	logic tx_valid_i = 1'b0;
	logic tx_last_i = 1'b0;
	logic op_ready_o, op_refused_o, rd_valid_o, rd_eoi_o, rx_valid_o, rx_end_o;
	logic tx_ready_o, listening_o, talking_o, b_rx_valid, b_listening, r, r2;
	logic [7:0] rd_data_o, rx_data_o;
	logic [7:0] fill [6] = '{8'h41, 8'h0A, 8'h00, 8'hFF, 8'h5A, 8'hC3};
	logic [7:0] m1_d [3] = '{8'h31, 8'h0D, 8'h0A};
	logic m1_e [3] = '{1'b0, 1'b1, 1'b1};
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;

	ib_bus_if bus ();
	ib_bus_if bus_b ();
	ib_host u_ib_host (.*);
	ib_device u_ib_device (.*);
	ib_device u_ib_device_b (.*, .bus(bus_b), .rx_valid_o(b_rx_valid), .rx_data_o(),
		.rx_end_o(), .tx_valid_i(1'b0), .tx_ready_o(), .listening_o(b_listening),
		.talking_o());
	ib_bus_monitor u_ib_bus_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i), .dio(bus.dio),
		.c_dio_oe(bus.c_dio_oe), .d_dio_oe(bus.d_dio_oe), .d_dav(bus.d_dav), .dav(bus.dav),
		.nrfd(bus.nrfd), .ndac(bus.ndac), .atn(bus.atn), .eoi(bus.eoi));

	// fault driver holds the unused controller lines released
	assign {bus_b.c_nrfd, bus_b.c_ndac, bus_b.c_eoi, bus_b.c_ifc, bus_b.c_ren} = 5'h00;

	// clock and hang limit
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			$display("ERROR run length expected finish seen hang");
			complete_run();
		end
	end

	// ----
	// shared tasks
	// ----
	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wait_ready();
		int n;
		n = 0;
		@(negedge clk_i);
		while (op_ready_o !== 1'b1 && n < 20000) begin
			@(negedge clk_i);
			n++;
		end
		check("op ready", 9'h001, op_ready_o);
	endtask : wait_ready

	task automatic host_op(input host_op_t op, input logic [4:0] a, input logic [7:0] d,
		input logic e, output logic refused);
		wait_ready();
		@(posedge clk_i);
		op_valid_i <= 1'b1;
		op_i <= op;
		op_addr_i <= a;
		op_data_i <= d;
		op_eoi_i <= e;
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		refused = 1'b0;
		repeat (3) begin
			@(negedge clk_i);
			refused = refused | (op_refused_o === 1'b1);
		end
	endtask : host_op

	task automatic do_cmd(input host_op_t op, input logic [4:0] a);
		logic rf;
		host_op(op, a, 8'h00, 1'b0, rf);
		check("command refused", 9'h000, rf);
		wait_ready();
	endtask : do_cmd

	task automatic read_byte(output logic [8:0] got);
		logic rf;
		int n;
		host_op(OP_READ, 5'h00, 8'h00, 1'b0, rf);
		n = 0;
		while (rd_valid_o !== 1'b1 && n < 2000) begin
			@(negedge clk_i);
			n++;
		end
		check("read strobe", 9'h001, rd_valid_o);
		got = {rd_eoi_o, rd_data_o};
	endtask : read_byte

	task automatic pop_check(input logic [7:0] d, input logic e);
		int n;
		n = 0;
		@(negedge clk_i);
		while (rx_valid_o !== 1'b1 && n < 5000) begin
			@(negedge clk_i);
			n++;
		end
		check("rx valid", 9'h001, rx_valid_o);
		check("rx byte", {e, d}, {rx_end_o, rx_data_o});
		@(posedge clk_i);
		rx_ready_i <= 1'b1;
		@(posedge clk_i);
		rx_ready_i <= 1'b0;
	endtask : pop_check

	task automatic dev_tx(input logic [7:0] d, input logic last);
		int n;
		n = 0;
		@(negedge clk_i);
		while (tx_ready_o !== 1'b1 && n < 20000) begin
			@(negedge clk_i);
			n++;
		end
		check("tx ready", 9'h001, tx_ready_o);
		@(posedge clk_i);
		tx_valid_i <= 1'b1;
		tx_data_i <= d;
		tx_last_i <= last;
		@(posedge clk_i);
		tx_valid_i <= 1'b0;
	endtask : dev_tx

	// device sources its reply while the host reads it back
	task automatic reply(input logic [7:0] tx [$], input logic [8:0] exp [$]);
		logic [8:0] got;
		fork
			foreach (tx[i]) dev_tx(tx[i], i == tx.size() - 1);
			foreach (exp[i]) begin
				read_byte(got);
				check("reply byte", exp[i], got);
			end
		join
	endtask : reply

	// one byte on the second bus, paced without waiting for the acceptor
	task automatic drive_b(input logic atn, input logic [7:0] d);
		@(posedge clk_i);
		bus_b.c_atn <= atn;
		bus_b.c_dio <= d;
		bus_b.c_dio_oe <= 1'b1;
		repeat (130) @(posedge clk_i);
		bus_b.c_dav <= 1'b1;
		repeat (40) @(posedge clk_i);
		bus_b.c_dav <= 1'b0;
		bus_b.c_dio_oe <= 1'b0;
		repeat (20) @(negedge clk_i);
	endtask : drive_b

	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	// ----
	// main sequence
	// ----
	initial begin
		bus_b.c_atn = 1'b0;
		bus_b.c_dio = 8'h00;
		bus_b.c_dio_oe = 1'b0;
		bus_b.c_dav = 1'b0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		check("roles at reset", 9'h000, {listening_o, talking_o, rx_valid_o});
		host_op(OP_DATA, 5'h00, 8'h11, 1'b0, r);
		check("data refused", 9'h001, r);
		host_op(OP_READ, 5'h00, 8'h00, 1'b0, r);
		check("read refused", 9'h001, r);
		do_cmd(OP_LISTEN, 5'h07);
		check("other address", 9'h000, listening_o);
		do_cmd(OP_UNLISTEN, 5'h00);
		do_cmd(OP_LISTEN, `ADDR_MAX);
		check("listen roles", 9'h002, {listening_o, talking_o});
		// six bytes into a four deep buffer with the reader stalled
		fork
			for (int i = 0; i < 6; i++) host_op(OP_DATA, 5'h00, fill[i], i == 5, r2);
		join_none
		repeat (2000) @(negedge clk_i);
		check("stall not ready", 9'h001, bus.nrfd);
		check("host held", 9'h000, op_ready_o);
		for (int i = 0; i < 6; i++) pop_check(fill[i], i == 5);
		wait fork;
		// carriage return and line feed convention
		@(posedge clk_i);
		term_mode_i <= `TERM_CRLF;
		for (int i = 0; i < 3; i++) host_op(OP_DATA, 5'h00, m1_d[i], m1_e[i], r);
		for (int i = 0; i < 3; i++) pop_check(m1_d[i], i == 2);
		do_cmd(OP_UNLISTEN, 5'h00);
		do_cmd(OP_TALK, `ADDR_MAX);
		check("talk roles", 9'h001, {listening_o, talking_o});
		reply('{8'h52}, '{9'h052, 9'h00D, 9'h10A});
		do_cmd(OP_UNTALK, 5'h00);
		@(posedge clk_i);
		term_mode_i <= `TERM_EOI;
		do_cmd(OP_TALK, `ADDR_MAX);
		reply('{8'h10, 8'h99}, '{9'h010, 9'h199});
		do_cmd(OP_TALK, 5'h07);
		check("untalked by other", 9'h000, talking_o);
		// interface clear drops the listener role
		do_cmd(OP_LISTEN, `ADDR_MAX);
		// clear held long enough to pass the three-stage input filter
		@(posedge clk_i);
		clear_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		clear_i <= 1'b0;
		repeat (20) @(negedge clk_i);
		check("cleared role", 9'h000, listening_o);
		host_op(OP_DATA, 5'h00, 8'h22, 1'b0, r);
		check("data after clear", 9'h001, r);
		// second bus: secondary address, unaddressed data, then own listen
		drive_b(1'b1, 8'h7E);
		check("secondary ignored", 9'h000, b_listening);
		drive_b(1'b0, 8'h55);
		check("unaddressed data", 9'h000, b_rx_valid);
		drive_b(1'b1, 8'h3E);
		check("listen by address", 9'h001, b_listening);
		complete_run();
	end
endmodule : tb_top
